// ===== rtl/ccsr_pkg.sv
// What this block does
// - On lockout entry, copy the supply path bit into a latch, then default it.
// - In lockout with a supply present, the latch steers charger and power path.
// - The latch clears to low only when input power is removed.
// - On lockout exit the latch is ignored and the register bit steers again.
// - A current reduction loop starting while no loop is active raises a charger status interrupt.
// - Supplement flag sets above 60 mV battery excess, clears below 20 mV.
// - Supplement flag changes never raise an interrupt.
// - Current scale code selects quarter, half, three quarters or full current.
// - A pack temperature fault freezes safety timers without resetting them; it does not gate charge enable.
// - Toggling supply path or charge run bit restarts timers and clears faults.
// - Termination disable holds the fast charge safety timer in reset.
package ccsr_pkg;

    // Register addresses on the register access port.
    localparam logic [7:0] ADDR_GEN_IO       = 8'h1C;
    localparam logic [7:0] ADDR_CHG_CONTROL  = 8'h1A;
    localparam logic [7:0] ADDR_CHG_STATUS   = 8'h1B;

    // Reset values.
    localparam logic [7:0] RST_CHG_CONTROL   = 8'hD8;
    localparam logic [7:0] RST_GEN_IO        = 8'h00;
    localparam logic       RST_PATH_LATCH    = 1'b0;
    localparam logic [7:0] UNMAPPED_READ     = 8'h00;

    // Charger control field positions.
    localparam int CTL_VOLTAGE_SELECT  = 7;
    localparam int CTL_CHARGE_RUN      = 6;
    localparam int CTL_TERM_DISABLE    = 5;
    localparam int CTL_SCALE_HI        = 4;
    localparam int CTL_SCALE_LO        = 3;
    localparam int CTL_USB_LIMIT       = 2;
    localparam int CTL_INPUT_LIMIT_MAX = 1;
    localparam int CTL_SUPPLY_PATH     = 0;

    // Shared general purpose register: only this bit touches the charger.
    localparam int GEN_IO_VOLTAGE_SAFETY = 4;

    // Charger status field positions.
    localparam int STS_SUPPLEMENT      = 7;
    localparam int STS_SELECTED_INPUT  = 6;
    localparam int STS_CURRENT_REDUCE  = 5;
    localparam int STS_WALL_PRESENT    = 4;
    localparam int STS_USB_PRESENT     = 3;
    localparam int STS_STATE_HI        = 2;
    localparam int STS_STATE_LO        = 1;
    localparam int STS_INPUT_OVP       = 0;

    // Charge state codes reported by the charger core.
    localparam logic [1:0] STATE_FAST      = 2'h2;
    localparam logic [1:0] STATE_PRECHARGE = 2'h3;

    // Supplement hysteresis thresholds, reported by analog comparators.
    localparam int SUPPLEMENT_SET_MV   = 60;
    localparam int SUPPLEMENT_CLEAR_MV = 20;

    // Safety timer time base and limits, counted in timer ticks.
    localparam int TICK_PERIOD_NS      = 1000000;
    localparam int CLK_PERIOD_NS       = 4;
    localparam int TICK_CYCLES         = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAST_LIMIT_TICKS    = 1000;
    localparam int PRE_LIMIT_TICKS     = FAST_LIMIT_TICKS / 10;

endpackage : ccsr_pkg

// ===== rtl/ccsr_safety_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ccsr_safety_timer #(
    parameter int LIMIT = 1000,
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic rst,
    // Control.
    input  wire logic tick,
    input  wire logic run,
    input  wire logic clear,
    // Status.
    output logic      fault
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic             next_fault;

    // Count ticks while running; a held-off run simply freezes the count.
    always_comb begin
        next_count = count;
        next_fault = fault;
        if (clear) begin
            next_count = '0;
            next_fault = 1'b0;
        end else if (tick && run && !fault) begin
            if (count == WIDTH'(LIMIT - 1)) begin
                next_fault = 1'b1;
            end else begin
                next_count = count + WIDTH'(1);
            end
        end
    end

    // State registers.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count <= '0;
            fault <= 1'b0;
        end else begin
            count <= next_count;
            fault <= next_fault;
        end
    end

endmodule : ccsr_safety_timer
`default_nettype wire

// ===== rtl/ccsr_top.sv
`timescale 1ns/1ps
`default_nettype none
module ccsr_top #(
    parameter int TICK_CYCLES = ccsr_pkg::TICK_CYCLES,
    parameter int FAST_LIMIT  = ccsr_pkg::FAST_LIMIT_TICKS,
    parameter int PRE_LIMIT   = ccsr_pkg::PRE_LIMIT_TICKS
) (
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Register access port from the serial interface engine.
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Live charger conditions.
    input  wire logic       undervoltage_lockout,
    input  wire logic       wall_input_present,
    input  wire logic       usb_input_present,
    input  wire logic       usb_selected,
    input  wire logic       dynamic_path_loop,
    input  wire logic       thermal_loop,
    input  wire logic       bat_above_out_set,
    input  wire logic       bat_above_out_clear,
    input  wire logic [1:0] charge_state_code,
    input  wire logic       input_overvoltage_flag,
    input  wire logic       pack_temp_fault,
    // Controls to the charger and power path.
    output logic            supply_path_effective,
    output logic            charge_enable,
    output logic            charge_voltage_high,
    output logic      [2:0] current_quarters,
    output logic            usb_limit_select,
    output logic            input_limit_max,
    output logic            supplement_flag,
    output logic            charger_status_event,
    output logic            precharge_timer_fault,
    output logic            fast_timer_fault,
    output logic      [7:0] general_io_three
);

    logic [7:0]  charger_control_reg;
    logic [7:0]  general_io_three_control;
    logic        supply_path_latch;
    logic        lockout_prev;
    logic        power_prev;
    logic        loop_prev;
    logic [31:0] tick_count;
    logic        tick_half;
    logic        timer_tick;
    logic [7:0]  next_control;
    logic [7:0]  next_gen_io;
    logic        next_latch;
    logic        next_supplement;
    logic [7:0]  next_rdata;
    logic [31:0] next_tick_count;
    logic        next_tick_half;
    logic        next_timer_tick;
    logic        next_event;
    logic        input_power;
    logic        lockout_entry;
    logic        new_cycle;
    logic        suspended;
    logic        current_reduction_flag;
    logic [7:0]  charger_status_reg;

    assign input_power            = wall_input_present | usb_input_present;
    assign lockout_entry          = undervoltage_lockout & ~lockout_prev;
    assign current_reduction_flag = dynamic_path_loop | thermal_loop;

    // Status is assembled from live inputs on every read, never stored.
    // Contents only mean something while an input supply is present.
    always_comb begin
        charger_status_reg                     = 8'h00;
        charger_status_reg[ccsr_pkg::STS_SUPPLEMENT]     = supplement_flag;
        charger_status_reg[ccsr_pkg::STS_SELECTED_INPUT] = usb_selected;
        charger_status_reg[ccsr_pkg::STS_CURRENT_REDUCE] = current_reduction_flag;
        charger_status_reg[ccsr_pkg::STS_WALL_PRESENT]   = wall_input_present;
        charger_status_reg[ccsr_pkg::STS_USB_PRESENT]    = usb_input_present;
        charger_status_reg[ccsr_pkg::STS_STATE_HI]       = charge_state_code[1];
        charger_status_reg[ccsr_pkg::STS_STATE_LO]       = charge_state_code[0];
        charger_status_reg[ccsr_pkg::STS_INPUT_OVP]      = input_overvoltage_flag;
    end

    // Register writes, lockout capture and read data.
    always_comb begin
        next_control = charger_control_reg;
        next_gen_io  = general_io_three_control;
        next_latch   = supply_path_latch;
        next_rdata   = reg_rdata;
        new_cycle    = 1'b0;
        if (reg_wr) begin
            if (reg_addr == ccsr_pkg::ADDR_CHG_CONTROL) begin
                next_control = reg_wdata;
                if ((reg_wdata[ccsr_pkg::CTL_SUPPLY_PATH] != charger_control_reg[ccsr_pkg::CTL_SUPPLY_PATH]) ||
                    (reg_wdata[ccsr_pkg::CTL_CHARGE_RUN] != charger_control_reg[ccsr_pkg::CTL_CHARGE_RUN])) begin
                    new_cycle = 1'b1;
                end
            end else if (reg_addr == ccsr_pkg::ADDR_GEN_IO) begin
                next_gen_io = reg_wdata;
            end
        end
        // Lockout entry wins over a same-cycle write: capture the live bit, then default it.
        if (lockout_entry) begin
            next_latch = charger_control_reg[ccsr_pkg::CTL_SUPPLY_PATH];
            next_control[ccsr_pkg::CTL_SUPPLY_PATH] = ccsr_pkg::RST_CHG_CONTROL[ccsr_pkg::CTL_SUPPLY_PATH];
        end else if (!input_power) begin
            next_latch = ccsr_pkg::RST_PATH_LATCH;
        end
        if (reg_rd) begin
            if (reg_addr == ccsr_pkg::ADDR_CHG_CONTROL) begin
                next_rdata = charger_control_reg;
            end else if (reg_addr == ccsr_pkg::ADDR_CHG_STATUS) begin
                next_rdata = charger_status_reg;
            end else if (reg_addr == ccsr_pkg::ADDR_GEN_IO) begin
                next_rdata = general_io_three_control;
            end else begin
                next_rdata = ccsr_pkg::UNMAPPED_READ;
            end
        end
    end

    // Supplement hysteresis: the comparators carry the 60 mV and 20 mV points.
    always_comb begin
        next_supplement = supplement_flag;
        if (bat_above_out_set) begin
            next_supplement = 1'b1;
        end else if (!bat_above_out_clear) begin
            next_supplement = 1'b0;
        end
    end

    // Only a rising current reduction loop raises the event; supplement has no path here.
    always_comb begin
        next_event = current_reduction_flag & ~loop_prev;
    end

    // Timer time base; with a reduction loop active every other tick is dropped,
    // which stretches the timeout by at most a factor of two.
    always_comb begin
        next_tick_count = tick_count + 32'h0000_0001;
        next_tick_half  = tick_half;
        next_timer_tick = 1'b0;
        if (tick_count == 32'(TICK_CYCLES - 1)) begin
            next_tick_count = 32'h0000_0000;
            next_tick_half  = ~tick_half;
            next_timer_tick = ~current_reduction_flag | tick_half;
        end
    end

    // State registers.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            charger_control_reg      <= ccsr_pkg::RST_CHG_CONTROL;
            general_io_three_control <= ccsr_pkg::RST_GEN_IO;
            supply_path_latch        <= ccsr_pkg::RST_PATH_LATCH;
            reg_rdata                <= 8'h00;
            supplement_flag          <= 1'b0;
            charger_status_event     <= 1'b0;
            lockout_prev             <= 1'b0;
            power_prev               <= 1'b0;
            loop_prev                <= 1'b0;
            tick_count               <= 32'h0000_0000;
            tick_half                <= 1'b0;
            timer_tick               <= 1'b0;
        end else begin
            charger_control_reg      <= next_control;
            general_io_three_control <= next_gen_io;
            supply_path_latch        <= next_latch;
            reg_rdata                <= next_rdata;
            supplement_flag          <= next_supplement;
            charger_status_event     <= next_event;
            lockout_prev             <= undervoltage_lockout;
            power_prev               <= input_power;
            loop_prev                <= current_reduction_flag;
            tick_count               <= next_tick_count;
            tick_half                <= next_tick_half;
            timer_tick               <= next_timer_tick;
        end
    end

    // Latch governs only in lockout with a supply present; otherwise the register bit.
    assign supply_path_effective = (undervoltage_lockout && input_power) ? supply_path_latch
                                 : charger_control_reg[ccsr_pkg::CTL_SUPPLY_PATH];
    assign charge_enable         = charger_control_reg[ccsr_pkg::CTL_CHARGE_RUN];
    // High voltage needs both the select bit low and the safety bit set, so a stray write cannot raise it.
    assign charge_voltage_high   = ~charger_control_reg[ccsr_pkg::CTL_VOLTAGE_SELECT]
                                 & general_io_three_control[ccsr_pkg::GEN_IO_VOLTAGE_SAFETY];
    assign current_quarters      = {1'b0, charger_control_reg[ccsr_pkg::CTL_SCALE_HI:ccsr_pkg::CTL_SCALE_LO]}
                                 + 3'h1;
    assign usb_limit_select      = charger_control_reg[ccsr_pkg::CTL_USB_LIMIT];
    assign input_limit_max       = charger_control_reg[ccsr_pkg::CTL_INPUT_LIMIT_MAX];
    assign general_io_three      = general_io_three_control;

    // Suspend freezes; a new cycle, lockout entry or input power return clears.
    assign suspended = ~charger_control_reg[ccsr_pkg::CTL_CHARGE_RUN] | pack_temp_fault;

    logic timers_clear;
    assign timers_clear = new_cycle | lockout_entry | (input_power & ~power_prev);

    ccsr_safety_timer #(
        .LIMIT (PRE_LIMIT),
        .WIDTH (32)
    ) u_precharge_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (timer_tick),
        .run      (~suspended && (charge_state_code == ccsr_pkg::STATE_PRECHARGE)),
        .clear    (timers_clear),
        .fault    (precharge_timer_fault)
    );

    ccsr_safety_timer #(
        .LIMIT (FAST_LIMIT),
        .WIDTH (32)
    ) u_fast_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (timer_tick),
        .run      (~suspended && (charge_state_code == ccsr_pkg::STATE_FAST)),
        .clear    (timers_clear | charger_control_reg[ccsr_pkg::CTL_TERM_DISABLE]),
        .fault    (fast_timer_fault)
    );

endmodule : ccsr_top
`default_nettype wire

// ===== tb/ccsr_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ccsr_top_assertions (
    // Clock and reset.
    input wire logic       core_clk,
    input wire logic       rst,
    // Register writes.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    // Charger conditions.
    input wire logic       undervoltage_lockout,
    input wire logic       wall_input_present,
    input wire logic       usb_input_present,
    input wire logic       dynamic_path_loop,
    input wire logic       thermal_loop,
    input wire logic       bat_above_out_set,
    input wire logic       bat_above_out_clear,
    // Watched outputs.
    input wire logic       supply_path_effective,
    input wire logic [2:0] current_quarters,
    input wire logic       supplement_flag,
    input wire logic       charger_status_event,
    input wire logic       fast_timer_fault
);
    logic [7:0] ctl;
    logic [7:0] next_ctl;
    logic       was_locked;
    logic       next_was_locked;
    wire logic  held  = undervoltage_lockout && (wall_input_present || usb_input_present);
    wire logic  loops = dynamic_path_loop || thermal_loop;
    // One, two, three or four quarters of the programmed current.
    wire logic [2:0] quarters_exp = ctl[4] ? (ctl[3] ? 3'h4 : 3'h3) : (ctl[3] ? 3'h2 : 3'h1);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Shadow of the control register; lockout entry beats a same-cycle write of the path bit.
    always_comb begin
        next_ctl        = ctl;
        next_was_locked = undervoltage_lockout;
        if (reg_wr && reg_addr == ccsr_pkg::ADDR_CHG_CONTROL) begin
            next_ctl = reg_wdata;
        end
        if (undervoltage_lockout && !was_locked) begin
            next_ctl[ccsr_pkg::CTL_SUPPLY_PATH] = 1'b0;
        end
    end
    // The shadow registers.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctl        <= ccsr_pkg::RST_CHG_CONTROL;
            was_locked <= 1'b0;
        end else begin
            ctl        <= next_ctl;
            was_locked <= next_was_locked;
        end
    end
    // The latch output is only trusted from the second cycle of lockout on.
    sequence s_entry;
        !undervoltage_lockout ##1 held ##1 held;
    endsequence
    sequence s_power_cut;
        (undervoltage_lockout && !held) [*2] ##1 held;
    endsequence
    a_path_register: assert property (!held |-> supply_path_effective == ctl[0])
        else $error("supply path does not follow the register bit");
    a_path_capture: assert property (s_entry |-> supply_path_effective == $past(ctl[0]))
        else $error("supply path latch missed the bit at lockout entry");
    a_path_hold: assert property (held [*3] |-> $stable(supply_path_effective))
        else $error("supply path moved during lockout");
    a_latch_cleared: assert property (s_power_cut |-> !supply_path_effective)
        else $error("supply path latch kept its value without input power");
    a_event_rise: assert property ($rose(loops) |=> charger_status_event)
        else $error("no status event after a current reduction loop started");
    a_event_cause: assert property (charger_status_event |-> $past(loops) && !$past(loops, 2))
        else $error("status event without a loop start");
    a_supp_set: assert property (bat_above_out_set |=> supplement_flag)
        else $error("supplement flag not set");
    a_supp_clear: assert property (!bat_above_out_set && !bat_above_out_clear |=> !supplement_flag)
        else $error("supplement flag not cleared");
    a_supp_hold: assert property (!bat_above_out_set && bat_above_out_clear |=> $stable(supplement_flag))
        else $error("supplement flag moved inside the hysteresis band");
    a_scale_map: assert property (current_quarters == quarters_exp)
        else $error("current scale does not match the control field");
    a_fast_held: assert property (ctl[ccsr_pkg::CTL_TERM_DISABLE] [*2] |-> !fast_timer_fault)
        else $error("fast timer fault while termination is disabled");
endmodule : ccsr_top_assertions
bind ccsr_top ccsr_top_assertions ccsr_top_assertions_inst (
    .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .undervoltage_lockout, .wall_input_present,
    .usb_input_present, .dynamic_path_loop, .thermal_loop, .bat_above_out_set, .bat_above_out_clear,
    .supply_path_effective, .current_quarters, .supplement_flag, .charger_status_event, .fast_timer_fault
);
`default_nettype wire

// ===== tb/ccsr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccsr_host_model (
    // Clock.
    input  wire logic       core_clk,
    // Register access port toward the charger.
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // Idle bus at time zero.
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // A one-cycle strobe; released lines show the inverse so stale values are never trusted.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : write_reg
    // Read data is registered, so it is taken once the sampling edge has landed.
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(negedge core_clk);
        d = reg_rdata;
    endtask : read_reg
endmodule : ccsr_host_model
`default_nettype wire

// ===== tb/ccsr_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ccsr_top_tb_top;
    logic core_clk = 1'b0, rst = 1'b1, reg_wr, reg_rd, undervoltage_lockout = 1'b0, wall_input_present = 1'b1;
    logic usb_input_present = 1'b0, usb_selected = 1'b0, dynamic_path_loop = 1'b0, thermal_loop = 1'b0;
    logic bat_above_out_set = 1'b0, bat_above_out_clear = 1'b0, input_overvoltage_flag = 1'b0, pack_temp_fault = 1'b0;
    logic [1:0] charge_state_code = 2'h0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, general_io_three, rd_val, d;
    logic supply_path_effective, charge_enable, charge_voltage_high, usb_limit_select, input_limit_max;
    logic supplement_flag, charger_status_event, precharge_timer_fault, fast_timer_fault, exp_supp = 1'b0;
    logic [2:0] current_quarters;
    logic [31:0] r;
    int miscompares = 0, comparisons = 0, seed = 75303;
    localparam logic [7:0] CTL = ccsr_pkg::ADDR_CHG_CONTROL;
    localparam logic [7:0] STS = ccsr_pkg::ADDR_CHG_STATUS;

    ccsr_top #(.TICK_CYCLES(4), .FAST_LIMIT(10), .PRE_LIMIT(3)) ccsr_top_inst (
        .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .undervoltage_lockout,
        .wall_input_present, .usb_input_present, .usb_selected, .dynamic_path_loop, .thermal_loop,
        .bat_above_out_set, .bat_above_out_clear, .charge_state_code, .input_overvoltage_flag, .pack_temp_fault,
        .supply_path_effective, .charge_enable, .charge_voltage_high, .current_quarters, .usb_limit_select,
        .input_limit_max, .supplement_flag, .charger_status_event, .precharge_timer_fault, .fast_timer_fault,
        .general_io_three);
    ccsr_host_model ccsr_host_model_inst (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

    // Live status as the charger should report it.
    function automatic logic [7:0] exp_status();
        return {exp_supp, usb_selected, dynamic_path_loop | thermal_loop, wall_input_present,
                usb_input_present, charge_state_code, input_overvoltage_flag};
    endfunction : exp_status
    // Quarters of the programmed current for each scale code.
    function automatic logic [7:0] exp_quarters(input logic [1:0] code);
        case (code)
            2'h0:    return 8'h01;
            2'h1:    return 8'h02;
            2'h2:    return 8'h03;
            default: return 8'h04;
        endcase
    endfunction : exp_quarters
    // Bus shorthands and settling waits.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        ccsr_host_model_inst.write_reg(a, v);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        ccsr_host_model_inst.read_reg(a, rd_val);
    endtask : rd
    task automatic hold(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : hold
    // Compare and count.
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Verdict.
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Clock.
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    // Cut a hang short; the whole run needs well under this.
    initial begin
        repeat (6000) @(posedge core_clk);
        miscompares++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        rd(CTL);
        chk("control reset", ccsr_pkg::RST_CHG_CONTROL, rd_val);
        rd(ccsr_pkg::ADDR_GEN_IO);
        chk("general io three reset", ccsr_pkg::RST_GEN_IO, rd_val);
        rd(8'h55);
        chk("unmapped read", ccsr_pkg::UNMAPPED_READ, rd_val);
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            d = 8'($random(seed));
            if (i < 4) d[4:3] = i[1:0];
            wr(CTL, d);
            wr(ccsr_pkg::ADDR_GEN_IO, ~d);
            rd(CTL);
            chk("control", d, rd_val);
            chk("quarters", exp_quarters(d[4:3]), {5'h00, current_quarters});
            chk("general io three", ~d, general_io_three);
            chk("voltage high", {7'h00, ~d[7] & ~d[4]}, {7'h00, charge_voltage_high});
            chk("charge run", {7'h00, d[6]}, {7'h00, charge_enable});
            chk("usb limit", {7'h00, d[2]}, {7'h00, usb_limit_select});
            chk("input limit", {7'h00, d[1]}, {7'h00, input_limit_max});
        end
        $display("test registers done");
        // Random live conditions; one input is always powered so status is meaningful.
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            @(posedge core_clk);
            wall_input_present     <= r[0];
            usb_input_present      <= r[1] | ~r[0];
            usb_selected           <= r[2];
            dynamic_path_loop      <= r[3];
            thermal_loop           <= r[4] & r[5];
            bat_above_out_set      <= r[6];
            bat_above_out_clear    <= r[6] | r[7];
            charge_state_code      <= r[9:8];
            input_overvoltage_flag <= r[10];
            exp_supp = r[6] | (r[7] & exp_supp);
            wr(STS, r[18:11]);
            rd(STS);
            chk("status", exp_status(), rd_val);
        end
        $display("test status done");
        @(posedge core_clk);
        dynamic_path_loop  <= 1'b0;
        thermal_loop       <= 1'b0;
        wall_input_present <= 1'b1;
        charge_state_code  <= 2'h0;
        wr(CTL, 8'hD9);
        @(posedge core_clk);
        undervoltage_lockout <= 1'b1;
        hold(2);
        chk("path latched", 8'h01, {7'h00, supply_path_effective});
        rd(CTL);
        chk("path bit default", 8'hD8, rd_val);
        @(posedge core_clk);
        wall_input_present <= 1'b0;
        usb_input_present  <= 1'b0;
        // Power stays off for two cycles so the latch clear assertion is exercised.
        repeat (2) @(posedge core_clk);
        wall_input_present <= 1'b1;
        hold(2);
        chk("latch cleared", 8'h00, {7'h00, supply_path_effective});
        wr(CTL, 8'hD9);
        hold(1);
        chk("latch governs", 8'h00, {7'h00, supply_path_effective});
        @(posedge core_clk);
        undervoltage_lockout <= 1'b0;
        hold(0);
        chk("path after exit", 8'h01, {7'h00, supply_path_effective});
        $display("test lockout done");
        @(posedge core_clk);
        charge_state_code <= ccsr_pkg::STATE_FAST;
        wr(CTL, 8'hD8);
        hold(60);
        chk("fast expiry", 8'h01, {7'h00, fast_timer_fault});
        wr(CTL, 8'h98);
        wr(CTL, 8'hD8);
        hold(1);
        chk("fast restart", 8'h00, {7'h00, fast_timer_fault});
        hold(22);
        @(posedge core_clk);
        pack_temp_fault <= 1'b1;
        hold(100);
        chk("fast frozen", 8'h00, {7'h00, fast_timer_fault});
        @(posedge core_clk);
        pack_temp_fault <= 1'b0;
        hold(28);
        chk("fast resumed", 8'h01, {7'h00, fast_timer_fault});
        wr(CTL, 8'hF8);
        hold(60);
        chk("fast held", 8'h00, {7'h00, fast_timer_fault});
        @(posedge core_clk);
        charge_state_code <= ccsr_pkg::STATE_PRECHARGE;
        hold(30);
        chk("precharge expiry", 8'h01, {7'h00, precharge_timer_fault});
        wr(CTL, 8'hF9);
        hold(1);
        chk("precharge restart", 8'h00, {7'h00, precharge_timer_fault});
        $display("test timers done");
        tally_and_finish();
    end
endmodule : ccsr_top_tb_top
`default_nettype wire
